// >>> clsg_props.sv
// Port checker for the limit block
`timescale 1ns/100ps
module clsg_props (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        MON_FAULT,
  input wire        EVT_VALID,
  input wire [1:0]  EVT_KIND,
  input wire        EVT_STATE,
  input wire        PROC_MODFLT,
  input wire        FAULT_LED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Bus answer shape
  a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  // Simulation events come as error then signal
  a_sim_order: assert property (EVT_VALID && EVT_KIND == 2'h2
    |=> EVT_VALID && EVT_KIND == 2'h1) else $error("sim event order");
  a_state_one: assert property (EVT_VALID && EVT_KIND != 2'h0
    |-> EVT_STATE) else $error("state of non-limit event");
  // Module fault image and lamp
  a_modflt_image: assert property (1'b1 |=>
    PROC_MODFLT == $past(MON_FAULT)) else $error("fault image");
  a_led_dark: assert property ((!MON_FAULT)[*2] |-> !FAULT_LED)
    else $error("lamp lit without fault");
  a_led_blink: assert property ((MON_FAULT && !FAULT_LED)[*8]
    |-> ##[1:4] (FAULT_LED || !MON_FAULT)) else $error("lamp no blink");
endmodule // clsg_props

bind clsg_top clsg_props u_props (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
  .MON_FAULT(MON_FAULT), .EVT_VALID(EVT_VALID), .EVT_KIND(EVT_KIND),
  .EVT_STATE(EVT_STATE), .PROC_MODFLT(PROC_MODFLT), .FAULT_LED(FAULT_LED));

// >>> clsg_regs.vh
// Register map, field positions, reset values and timing for the limit block
`ifndef CLSG_REGS_VH
`define CLSG_REGS_VH

// Register byte addresses
`define CLSG_A_CTRL      12'h000
`define CLSG_A_CHAN_EN   12'h004
`define CLSG_A_SIM_EN    12'h008
`define CLSG_A_EVT_EN    12'h00c
`define CLSG_A_SUBST_EN  12'h010
`define CLSG_A_DIAG      12'h014
`define CLSG_A_IMG_LO    12'h018
`define CLSG_A_IMG_HI    12'h01c
`define CLSG_A_STATUS    12'h020
`define CLSG_A_SIM_BASE  12'h040
`define CLSG_A_LIM_BASE  12'h100

// Limit configuration word fields
`define CLSG_F_LIM_LSB   0
`define CLSG_F_LIM_MSB   15
`define CLSG_F_HYS_LSB   16
`define CLSG_F_HYS_MSB   27
`define CLSG_F_SUBST     28
`define CLSG_F_UPPER     30
`define CLSG_F_ENABLE    31

// Status word fields
`define CLSG_F_MODFLT    16

// Diagnostic flag positions
`define CLSG_D_OVF1      0
`define CLSG_D_PERIOD    6

// Event kinds
`define CLSG_EV_LIMIT    2'h0
`define CLSG_EV_SIMSIG   2'h1
`define CLSG_EV_SIMERR   2'h2
`define CLSG_EV_MODFLT   2'h3

// Reset values
`define CLSG_RST_CTRL    32'h0000_0000
`define CLSG_RST_LIM     32'h0000_0000

// Timing
`define CLSG_CLK_KHZ     250000
`define CLSG_T_LE4_MS    25
`define CLSG_T_LE8_MS    40
`define CLSG_T_LE12_MS   50
`define CLSG_T_LE16_MS   60
`define CLSG_T_BLINK_MS  500
`define CLSG_CYC(ms)     ((ms) * `CLSG_CLK_KHZ)

`endif

// >>> clsg_sink.sv
// Event sink standing for the higher automation level
`timescale 1ns/100ps
module clsg_sink (
  input  wire       CLK,
  input  wire       RST,
  input  wire       stall,
  input  wire       EVT_VALID,
  output reg        EVT_READY,
  output reg  [7:0] taken
);
  // Ready is the inverse of stall, one cycle later; accepted events counted
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      EVT_READY <= 1'b0;
      taken     <= 8'h00;
    end else begin
      EVT_READY <= !stall;
      if (EVT_VALID && EVT_READY)
        taken <= taken + 8'h01;
    end
  end
endmodule // clsg_sink

// >>> clsg_top.v
// Per-channel limit signal generator with simulation and fault signalling
// What this block does
// - Four configurable limits per input channel
// - Upper limit asserts when value reaches limit
// - Upper releases below limit minus hysteresis
// - Lower limit asserts when value at/below limit
// - Lower releases once value is above limit
// - All limit states go to image
// - Change emits tagged event if channel and its events enabled
// - Channel fault substitutes enabled limit states
// - Simulation replaces measured value when active
// - Simulated channel flagged in process image
// - Monitor fault: image, event, blinking lamp
// - Readable sticky diagnostic flags kept
// - Evaluation period follows selected channel count
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "clsg_regs.vh"

module clsg_top #(
  parameter NCH      = 16,
  parameter VW       = 16,
  parameter PER_LE4  = `CLSG_CYC(`CLSG_T_LE4_MS),
  parameter PER_LE8  = `CLSG_CYC(`CLSG_T_LE8_MS),
  parameter PER_LE12 = `CLSG_CYC(`CLSG_T_LE12_MS),
  parameter PER_LE16 = `CLSG_CYC(`CLSG_T_LE16_MS),
  parameter PER_BLK  = `CLSG_CYC(`CLSG_T_BLINK_MS)
) (
  input  wire            CLK,
  input  wire            RST,
  input  wire            PSEL,
  input  wire            PENABLE,
  input  wire            PWRITE,
  input  wire [11:0]     PADDR,
  input  wire [31:0]     PWDATA,
  output reg  [31:0]     PRDATA,
  output reg             PREADY,
  output reg             PSLVERR,
  input  wire            CH_VALID,
  input  wire [3:0]      CH_IDX,
  input  wire [VW-1:0]   CH_VALUE,
  input  wire [NCH-1:0]  CH_FAULT,
  input  wire            MON_FAULT,
  input  wire [7:0]      DIAG_IN,
  input  wire            EVT_READY,
  output reg             EVT_VALID,
  output reg  [1:0]      EVT_KIND,
  output reg  [3:0]      EVT_CHAN,
  output reg  [1:0]      EVT_LIMIT,
  output reg             EVT_STATE,
  output reg  [31:0]     EVT_TIME,
  output reg  [63:0]     PROC_LIMITS,
  output reg  [NCH-1:0]  PROC_SIM,
  output reg             PROC_MODFLT,
  output reg             FAULT_LED
);

  localparam S_IDLE = 1'b0;
  localparam S_RUN  = 1'b1;
  localparam [31:0] RST_CTRL = `CLSG_RST_CTRL;

  // Register file and stored values
  reg [31:0]    lim_cfg_r [0:63];
  reg [VW-1:0]  sim_val_r [0:NCH-1];
  reg [VW-1:0]  ch_val_r  [0:NCH-1];
  reg           run_r;
  reg [NCH-1:0] chan_en_r;
  reg [NCH-1:0] evt_en_r;
  reg [NCH-1:0] subst_en_r;
  reg [NCH-1:0] sim_pend_r;
  reg [7:0]     diag_r;
  reg           mf_pend_r;
  reg           mf_prev_r;
  reg [31:0]    per_cnt_r;
  reg [31:0]    blk_cnt_r;
  reg [31:0]    time_r;
  reg           state_r;
  reg [3:0]     ch_r;
  reg [2:0]     step_r;
  integer       i;

  // Bus decode
  wire          setup   = PSEL & ~PENABLE;
  wire          wr_acc  = PSEL & PENABLE & PREADY & PWRITE;
  wire          in_sim  = PADDR[11:6] == `CLSG_A_SIM_BASE >> 6;
  wire          in_lim  = PADDR[11:8] == `CLSG_A_LIM_BASE >> 8;
  wire [5:0]    lim_ix  = PADDR[7:2];
  wire [3:0]    sim_ix  = PADDR[5:2];

  // Channel selection count sets period
  function [4:0] popcnt;
    input [NCH-1:0] v;
    integer k;
    begin
      popcnt = 5'h00;
      for (k = 0; k < NCH; k = k + 1)
        popcnt = popcnt + {4'h0, v[k]};
    end
  endfunction

  wire [4:0]  nsel = popcnt(chan_en_r);
  reg  [31:0] period;
  always @* begin
    if (nsel <= 5'd4)
      period = PER_LE4;
    else if (nsel <= 5'd8)
      period = PER_LE8;
    else if (nsel <= 5'd12)
      period = PER_LE12;
    else
      period = PER_LE16;
  end
  wire tick = run_r & (per_cnt_r >= period - 32'h1);

  // Current limit under evaluation
  wire [5:0]    lx    = {ch_r, step_r[1:0]};
  wire [31:0]   cfg   = lim_cfg_r[lx];
  wire [VW-1:0] val   = PROC_SIM[ch_r] ? sim_val_r[ch_r] : ch_val_r[ch_r];
  wire signed [VW+1:0] v_s = {2'b00, val};
  wire signed [VW+1:0] l_s = {2'b00, cfg[`CLSG_F_LIM_MSB:`CLSG_F_LIM_LSB]};
  wire signed [VW+1:0] h_s = {{(VW-10){1'b0}},
                              cfg[`CLSG_F_HYS_MSB:`CLSG_F_HYS_LSB]};
  wire signed [VW+1:0] rel = l_s - h_s;
  wire          cur   = PROC_LIMITS[lx];
  reg           nst;

  // Next limit state
  always @* begin
    nst = cur;
    if (!cfg[`CLSG_F_ENABLE])
      nst = 1'b0;
    else if (CH_FAULT[ch_r] & subst_en_r[ch_r])
      nst = cfg[`CLSG_F_SUBST];
    else if (cfg[`CLSG_F_UPPER]) begin
      if (v_s >= l_s)
        nst = 1'b1;
      else if (v_s < rel)
        nst = 1'b0;
    end else begin
      if (v_s <= l_s)
        nst = 1'b1;
      else if (v_s > rel)
        nst = 1'b0;
    end
  end

  wire eval    = (state_r == S_RUN) & ~step_r[2] & chan_en_r[ch_r];
  wire chg     = eval & (nst != cur);
  wire ev_lim  = chg & evt_en_r[ch_r] & cfg[`CLSG_F_ENABLE];
  wire ev_serr = (state_r == S_RUN) & (step_r == 3'd4) & sim_pend_r[ch_r];
  wire ev_ssig = (state_r == S_RUN) & (step_r == 3'd5) & sim_pend_r[ch_r];
  wire ev_seq  = ev_lim | ev_serr | ev_ssig;
  wire ev_mf   = mf_pend_r & ~ev_seq;
  wire ev_any  = ev_seq | ev_mf;
  wire [NCH-1:0] sim_new = PWDATA[NCH-1:0];
  wire [NCH-1:0] ch_bit  = {{(NCH-1){1'b0}}, 1'b1} << ch_r;
  wire wr_sim  = wr_acc & (PADDR == `CLSG_A_SIM_EN);

  // APB slave read path and write side effects
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA     <= 32'h0000_0000;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
      run_r      <= RST_CTRL[0];
      chan_en_r  <= {NCH{1'b0}};
      evt_en_r   <= {NCH{1'b0}};
      subst_en_r <= {NCH{1'b0}};
      PROC_SIM   <= {NCH{1'b0}};
      for (i = 0; i < 64; i = i + 1)
        lim_cfg_r[i] <= `CLSG_RST_LIM;
      for (i = 0; i < NCH; i = i + 1)
        sim_val_r[i] <= {VW{1'b0}};
    end else begin
      PREADY  <= setup;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (setup & ~PWRITE) begin
        case (PADDR)
          `CLSG_A_CTRL:     PRDATA <= {31'h0, run_r};
          `CLSG_A_CHAN_EN:  PRDATA <= {16'h0, chan_en_r};
          `CLSG_A_SIM_EN:   PRDATA <= {16'h0, PROC_SIM};
          `CLSG_A_EVT_EN:   PRDATA <= {16'h0, evt_en_r};
          `CLSG_A_SUBST_EN: PRDATA <= {16'h0, subst_en_r};
          `CLSG_A_DIAG:     PRDATA <= {24'h0, diag_r};
          `CLSG_A_IMG_LO:   PRDATA <= PROC_LIMITS[31:0];
          `CLSG_A_IMG_HI:   PRDATA <= PROC_LIMITS[63:32];
          `CLSG_A_STATUS:   PRDATA <= {15'h0, PROC_MODFLT, PROC_SIM};
          default: begin
            if (in_lim)
              PRDATA <= lim_cfg_r[lim_ix];
            else if (in_sim)
              PRDATA <= {16'h0, sim_val_r[sim_ix]};
            else
              PSLVERR <= 1'b1;
          end
        endcase
      end
      if (setup & PWRITE)
        PSLVERR <= ~(in_lim | in_sim | PADDR <= `CLSG_A_SUBST_EN |
                     PADDR == `CLSG_A_DIAG);
      if (wr_acc) begin
        case (PADDR)
          `CLSG_A_CTRL:     run_r      <= PWDATA[0];
          `CLSG_A_CHAN_EN:  chan_en_r  <= PWDATA[NCH-1:0];
          `CLSG_A_SIM_EN:   PROC_SIM   <= sim_new;
          `CLSG_A_EVT_EN:   evt_en_r   <= PWDATA[NCH-1:0];
          `CLSG_A_SUBST_EN: subst_en_r <= PWDATA[NCH-1:0];
          default: begin
            if (in_lim)
              lim_cfg_r[lim_ix] <= PWDATA;
            else if (in_sim)
              sim_val_r[sim_ix] <= PWDATA[VW-1:0];
          end
        endcase
      end
    end
  end

  // Latest measured value per channel
  always @(posedge CLK) begin
    if (CH_VALID)
      ch_val_r[CH_IDX] <= CH_VALUE;
  end

  // Sampling timer and channel walk
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      per_cnt_r <= 32'h0;
      state_r   <= S_IDLE;
      ch_r      <= 4'h0;
      step_r    <= 3'h0;
    end else begin
      per_cnt_r <= (tick | ~run_r) ? 32'h0 : per_cnt_r + 32'h1;
      case (state_r)
        S_IDLE: begin
          if (tick) begin
            state_r <= S_RUN;
            ch_r    <= 4'h0;
            step_r  <= 3'h0;
          end
        end
        S_RUN: begin
          if (step_r == 3'd5) begin
            step_r <= 3'h0;
            ch_r   <= ch_r + 4'h1;
            if (ch_r == NCH - 1)
              state_r <= S_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Limit states, pending events and event output
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PROC_LIMITS <= 64'h0;
      sim_pend_r  <= {NCH{1'b0}};
      mf_pend_r   <= 1'b0;
      mf_prev_r   <= 1'b0;
      diag_r      <= 8'h00;
      time_r      <= 32'h0;
      EVT_VALID   <= 1'b0;
      EVT_KIND    <= 2'h0;
      EVT_CHAN    <= 4'h0;
      EVT_LIMIT   <= 2'h0;
      EVT_STATE   <= 1'b0;
      EVT_TIME    <= 32'h0;
    end else begin
      time_r    <= time_r + 32'h1;
      mf_prev_r <= MON_FAULT;
      if (eval)
        PROC_LIMITS[lx] <= nst;
      sim_pend_r <= (sim_pend_r & ~(ev_ssig ? ch_bit : {NCH{1'b0}}))
                    | (wr_sim ? (sim_new & ~PROC_SIM) : {NCH{1'b0}});
      mf_pend_r <= (mf_pend_r & ~ev_mf) | (MON_FAULT & ~mf_prev_r);
      diag_r <= (diag_r & ~(wr_acc & PADDR == `CLSG_A_DIAG ?
                            PWDATA[7:0] : 8'h00))
                | DIAG_IN
                | ({7'h0, ev_any & ~EVT_READY} << `CLSG_D_OVF1)
                | ({7'h0, tick & (state_r == S_RUN)} << `CLSG_D_PERIOD);
      EVT_VALID <= ev_any;
      if (ev_any) begin
        EVT_TIME  <= time_r;
        EVT_CHAN  <= ev_seq ? ch_r : 4'h0;
        EVT_LIMIT <= ev_lim ? step_r[1:0] : 2'h0;
        EVT_STATE <= ev_lim ? nst : 1'b1;
        if (ev_lim)
          EVT_KIND <= `CLSG_EV_LIMIT;
        else if (ev_serr)
          EVT_KIND <= `CLSG_EV_SIMERR;
        else if (ev_ssig)
          EVT_KIND <= `CLSG_EV_SIMSIG;
        else
          EVT_KIND <= `CLSG_EV_MODFLT;
      end
    end
  end

  // fault in image and blinking lamp
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PROC_MODFLT <= 1'b0;
      FAULT_LED   <= 1'b0;
      blk_cnt_r   <= 32'h0;
    end else begin
      PROC_MODFLT <= MON_FAULT;
      if (!MON_FAULT) begin
        FAULT_LED <= 1'b0;
        blk_cnt_r <= 32'h0;
      end else if (blk_cnt_r >= PER_BLK - 1) begin
        FAULT_LED <= ~FAULT_LED;
        blk_cnt_r <= 32'h0;
      end else begin
        blk_cnt_r <= blk_cnt_r + 32'h1;
      end
    end
  end

endmodule // clsg_top

// >>> clsg_top_bench.sv
// Self-checking bench for the limit block
`timescale 1ns/100ps
`include "clsg_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t %h %h", $time, (a), (b)); end end
module clsg_top_bench;
  localparam P = 200;
  localparam P8 = 300;
  logic        CLK = 1'b0;
  logic        RST, PSEL, PENABLE, PWRITE, CH_VALID, MON_FAULT, stall, e;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, q, t;
  logic [15:0] CH_VALUE, CH_FAULT;
  logic [7:0]  DIAG_IN;
  logic [3:0]  CH_IDX;
  wire  [31:0] PRDATA, EVT_TIME;
  wire  [63:0] PROC_LIMITS;
  wire  [15:0] PROC_SIM;
  wire  [7:0]  taken;
  wire  [3:0]  EVT_CHAN;
  wire  [1:0]  EVT_KIND, EVT_LIMIT;
  wire         PREADY, PSLVERR, EVT_READY, EVT_VALID, EVT_STATE;
  wire         PROC_MODFLT, FAULT_LED;
  integer      checked = 0, mismatches = 0, n;

  clsg_top #(.PER_LE4(P), .PER_LE8(P8), .PER_LE12(400), .PER_LE16(500),
    .PER_BLK(8)) DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CH_VALID(CH_VALID), .CH_IDX(CH_IDX), .CH_VALUE(CH_VALUE),
    .CH_FAULT(CH_FAULT), .MON_FAULT(MON_FAULT), .DIAG_IN(DIAG_IN),
    .EVT_READY(EVT_READY), .EVT_VALID(EVT_VALID), .EVT_KIND(EVT_KIND),
    .EVT_CHAN(EVT_CHAN), .EVT_LIMIT(EVT_LIMIT), .EVT_STATE(EVT_STATE),
    .EVT_TIME(EVT_TIME), .PROC_LIMITS(PROC_LIMITS), .PROC_SIM(PROC_SIM),
    .PROC_MODFLT(PROC_MODFLT), .FAULT_LED(FAULT_LED));
  clsg_sink u_sink (.CLK(CLK), .RST(RST), .stall(stall),
    .EVT_VALID(EVT_VALID), .EVT_READY(EVT_READY), .taken(taken));

  // Clock, 4 ns period
  always #2 CLK = ~CLK;

  task complete_run;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer i;
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      for (i = 0; PREADY !== 1'b1 && i < 20; i++)
        @(posedge CLK);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (i == 20) begin
        mismatches++;
        complete_run;
      end
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    begin
      apb(1'b0, a, 32'h0);
      `CHK({q, e}, {x, xe});
    end
  endtask
  task setv(input integer c, input logic [15:0] v);
    begin
      @(posedge CLK);
      CH_VALID <= 1'b1;
      CH_IDX <= c[3:0];
      CH_VALUE <= v;
      @(posedge CLK);
      CH_VALID <= 1'b0;
    end
  endtask
  task evt(input logic [1:0] k, input logic [1:0] l, input logic s);
    integer i;
    begin
      @(posedge CLK);
      for (i = 0; EVT_VALID !== 1'b1 && i < 600; i++)
        @(posedge CLK);
      if (i == 600) begin
        mismatches++;
        complete_run;
      end
      `CHK({EVT_KIND, EVT_STATE}, {k, s});
      if (k != 2'h3)
        `CHK(EVT_CHAN, 4'h0);
      if (k == 2'h0)
        `CHK(EVT_LIMIT, l);
    end
  endtask
  task idle;
    repeat (2 * P + 100) @(posedge CLK);
  endtask
  // Upper limit, disabled limit beside it
  task upper;
    begin
      rd(`CLSG_A_CTRL, `CLSG_RST_CTRL, 1'b0);
      rd(12'h024, 32'h0, 1'b1);
      apb(1'b1, `CLSG_A_LIM_BASE + 12'h008, 32'h4000_0000);
      apb(1'b1, `CLSG_A_LIM_BASE, 32'hc00a_0064);
      apb(1'b1, `CLSG_A_EVT_EN, 32'h1);
      apb(1'b1, `CLSG_A_CHAN_EN, 32'h1);
      apb(1'b1, `CLSG_A_CTRL, 32'h1);
      setv(0, 16'd100);
      evt(2'h0, 2'h0, 1'b1);
      `CHK(PROC_LIMITS[3:0], 4'h1);
      setv(0, 16'd91);
      idle;
      `CHK(PROC_LIMITS[0], 1'b1);
      setv(0, 16'd89);
      evt(2'h0, 2'h0, 1'b0);
      rd(`CLSG_A_IMG_LO, 32'h0, 1'b0);
    end
  endtask
  // Lower limit assert and release
  task lower;
    begin
      apb(1'b1, `CLSG_A_LIM_BASE + 12'h004, 32'h8005_0032);
      setv(0, 16'd50);
      evt(2'h0, 2'h1, 1'b1);
      setv(0, 16'd51);
      evt(2'h0, 2'h1, 1'b0);
    end
  endtask
  // Simulation then fault substitution
  task simsub;
    begin
      apb(1'b1, `CLSG_A_SIM_BASE, 32'd120);
      apb(1'b1, `CLSG_A_SIM_EN, 32'h1);
      repeat (2) @(posedge CLK);
      `CHK(PROC_SIM[0], 1'b1);
      evt(2'h0, 2'h0, 1'b1);
      evt(2'h2, 2'h0, 1'b1);
      t = EVT_TIME;
      evt(2'h1, 2'h0, 1'b1);
      `CHK(EVT_TIME, t + 32'h1);
      apb(1'b1, `CLSG_A_LIM_BASE + 12'h004, 32'h9005_0032);
      apb(1'b1, `CLSG_A_SUBST_EN, 32'h1);
      CH_FAULT <= 16'h0001;
      evt(2'h0, 2'h0, 1'b0);
      evt(2'h0, 2'h1, 1'b1);
    end
  endtask
  // Lost events, then events switched off
  task quiet;
    begin
      stall <= 1'b1;
      CH_FAULT <= 16'h0000;
      idle;
      `CHK(PROC_LIMITS[3:0], 4'h1);
      rd(`CLSG_A_DIAG, 32'h1, 1'b0);
      apb(1'b1, `CLSG_A_DIAG, 32'h1);
      rd(`CLSG_A_DIAG, 32'h0, 1'b0);
      DIAG_IN <= 8'h30;
      @(posedge CLK);
      DIAG_IN <= 8'h00;
      rd(`CLSG_A_DIAG, 32'h30, 1'b0);
      stall <= 1'b0;
      apb(1'b1, `CLSG_A_EVT_EN, 32'h0);
      n = taken;
      CH_FAULT <= 16'h0001;
      idle;
      `CHK(taken, n[7:0]);
      `CHK(PROC_LIMITS[3:0], 4'h2);
    end
  endtask
  // Module fault event, image and lamp
  task modflt;
    begin
      apb(1'b1, `CLSG_A_EVT_EN, 32'h1);
      MON_FAULT <= 1'b1;
      evt(2'h3, 2'h0, 1'b1);
      repeat (30) @(posedge CLK);
      rd(`CLSG_A_STATUS, 32'h0001_0001, 1'b0);
      MON_FAULT <= 1'b0;
      repeat (3) @(posedge CLK);
      `CHK(FAULT_LED, 1'b0);
    end
  endtask
  // Five channels selected, walks one longer period apart
  task pace;
    begin
      apb(1'b1, `CLSG_A_CHAN_EN, 32'h1f);
      CH_FAULT <= 16'h0000;
      evt(2'h0, 2'h0, 1'b1);
      t = EVT_TIME;
      evt(2'h0, 2'h1, 1'b0);
      CH_FAULT <= 16'h0001;
      evt(2'h0, 2'h0, 1'b0);
      `CHK(EVT_TIME, t + P8);
      evt(2'h0, 2'h1, 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, CH_VALID, MON_FAULT, stall} = 6'h00;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    CH_IDX = 4'h0;
    CH_VALUE = 16'h0000;
    CH_FAULT = 16'h0000;
    DIAG_IN = 8'h00;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    for (n = 0; n < 16; n++)
      setv(n, 16'h0000);
    upper;
    lower;
    simsub;
    quiet;
    modflt;
    pace;
    complete_run;
  end
endmodule // clsg_top_bench
